// file: rtl/wdg_params.svh
// Function
// R1: decrement count every 16384 divided oscillator cycles
// R2: countdown runs even when not activated
// R3: activated, 40h to 3Fh gives reset pulse
// R4: software refreshes with values FFh down to C0h
// R5: low six bits set timeout in 64 steps
// R6: activate bit clears only on reset
// R7: activate with counter_msb clear forces reset
// R8: halt with halt option resets if active
// R9: plain halt: one decrement, then stopped
// R10: external wake restarts count after 256/4096 clocks
// R11: reset leaves watchdog deactivated unless hardware option
// R12: active-halt holds count, no reset
// R13: active-halt wake: interrupt immediate, reset delayed
// R14: slow and wait modes change nothing
// R15: prescaler phase makes timeout vary min to max
// R16: timebase select maps to MSB/LSB constants
// R17: startup option selects hardware watchdog mode
// R18: hardware option: always active, activate ignored
// R19: control reg: bit7 activate, 6:0 count, 7Fh
// R20: control writes never restart the prescaler
`ifndef WDG_PARAMS_SVH
`define WDG_PARAMS_SVH

// register indices, byte address is four times the index
`define WDG_CTRL_IDX 8'h2A
`define WDG_CFG_IDX 8'h2B
`define WDG_STAT_IDX 8'h2C
`define WDG_TBINFO_IDX 8'h2D

`define WDG_CTRL_RESET 8'h7F
`define WDG_CFG_RESET 8'h00
`define WDG_ACT_BIT 7
`define WDG_MSB_BIT 6
`define WDG_CFG_RTC_BIT 1
`define WDG_CFG_TB_LO 2

`define WDG_PRE_MAX 14'h3FFF
`define WDG_WAKE_SHORT 13'h0100
`define WDG_WAKE_LONG 13'h1000

`define WDG_CLK_MHZ 40
`define WDG_RST_NS 500
`define WDG_RST_CYC ((`WDG_RST_NS * `WDG_CLK_MHZ + 999) / 1000)

`define WDG_TB0_MSB 8'h04
`define WDG_TB0_LSB 8'h3B
`define WDG_TB1_MSB 8'h08
`define WDG_TB1_LSB 8'h35
`define WDG_TB2_MSB 8'h14
`define WDG_TB2_LSB 8'h23
`define WDG_TB3_MSB 8'h31
`define WDG_TB3_LSB 8'h36

`endif

// file: rtl/wdg_pkg.sv
package wdg_pkg;
    typedef logic [31:0] wdg_word_t;
    typedef logic [7:0] wdg_byte_t;
    typedef enum logic [4:0] {
        WDG_RUN = 5'b0_0001,
        WDG_HALT_ONE = 5'b0_0010,
        WDG_HALT_STOP = 5'b0_0100,
        WDG_AHALT = 5'b0_1000,
        WDG_WAKE = 5'b1_0000
    } wdg_state_t;
endpackage

// file: rtl/wdg_top.sv
`timescale 1ns/10ps
`include "wdg_params.svh"
module wdg_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire wdg_pkg::wdg_word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire wdg_pkg::wdg_word_t hwdata,
    input wire logic hready,
    output wdg_pkg::wdg_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_tick,
    input wire logic halt_req,
    input wire logic ext_wake,
    input wire logic osc_wake,
    input wire logic pin_hw_wdg_opt,
    input wire logic pin_halt_reset_opt,
    input wire logic pin_long_wake_opt,
    output logic wdg_reset_n,
    output logic wdg_active
);
    import wdg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input wdg_byte_t idx, input wdg_byte_t want);
        reg_hit = (idx == want);
    endfunction

    function automatic logic [15:0] tb_info(input logic [1:0] tb);
        case (tb)
            2'b00: tb_info = {`WDG_TB0_MSB, `WDG_TB0_LSB};
            2'b01: tb_info = {`WDG_TB1_MSB, `WDG_TB1_LSB};
            2'b10: tb_info = {`WDG_TB2_MSB, `WDG_TB2_LSB};
            default: tb_info = {`WDG_TB3_MSB, `WDG_TB3_LSB};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // option pins, two flops before use
    logic [2:0] opt_meta_reg;
    logic [2:0] opt_sync_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_meta_reg <= 3'h0;
            opt_sync_reg <= 3'h0;
        end else if (ce) begin
            opt_meta_reg <= {pin_long_wake_opt, pin_halt_reset_opt, pin_hw_wdg_opt};
            opt_sync_reg <= opt_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus address phase
    logic bus_wr_reg;
    logic bus_wr_next;
    logic bus_ok_reg;
    logic bus_ok_next;
    wdg_byte_t bus_idx_reg;
    wdg_byte_t bus_idx_next;
    wdg_word_t hrdata_next;
    logic addr_phase;
    logic addr_ok;
    wdg_byte_t addr_idx;

    // core state
    wdg_state_t state_reg;
    wdg_state_t state_next;
    logic act_reg;
    logic act_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [13:0] pre_reg;
    logic [13:0] pre_next;
    logic [12:0] wait_reg;
    logic [12:0] wait_next;
    logic [4:0] rst_cnt_reg;
    logic [4:0] rst_cnt_next;
    wdg_byte_t cfg_reg;
    wdg_byte_t cfg_next;
    logic boot_reg;
    logic boot_next;
    logic [2:0] opt_reg;
    logic [2:0] opt_next;
    logic active_next;
    logic wr_ctrl;
    logic tick;
    logic fire;
    logic halted;
    logic rtc_en;
    logic hw_opt;
    logic halt_opt;
    logic [12:0] wake_cyc;
    wdg_byte_t stat_val;

    assign addr_phase = hsel && hready && htrans[1];
    assign addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign addr_idx = haddr[9:2];
    assign rtc_en = cfg_reg[`WDG_CFG_RTC_BIT];
    assign hw_opt = opt_reg[0];
    assign halt_opt = opt_reg[1];
    assign wake_cyc = opt_reg[2] ? `WDG_WAKE_LONG : `WDG_WAKE_SHORT;
    assign halted = (state_reg == WDG_HALT_ONE) || (state_reg == WDG_HALT_STOP)
        || (state_reg == WDG_AHALT);

    ////////////////////////////////////////////////////////////////////////
    // core next state
    always_comb begin
        state_next = state_reg;
        act_next = act_reg;
        cnt_next = cnt_reg;
        pre_next = pre_reg;
        wait_next = wait_reg;
        cfg_next = cfg_reg;
        boot_next = boot_reg;
        opt_next = opt_reg;
        rst_cnt_next = rst_cnt_reg;
        fire = 1'b0;
        wr_ctrl = bus_wr_reg && bus_ok_reg && reg_hit(bus_idx_reg, `WDG_CTRL_IDX);

        // prescaler only follows the oscillator tick
        // R20: prescaler untouched by writes
        if (osc_tick) begin
            pre_next = pre_reg + 14'h0001;
        end
        // R1: one step per 16384 ticks
        tick = osc_tick && (pre_reg == `WDG_PRE_MAX);

        // R2: countdown free-running in run state
        // R12: held in active-halt and stopped states
        if (tick && ((state_reg == WDG_RUN) || (state_reg == WDG_HALT_ONE))) begin
            cnt_next = cnt_reg - 7'h01;
        end

        // R19: control register write
        // R5: low bits load timeout length
        if (wr_ctrl) begin
            cnt_next = hwdata[6:0];
            // R6: activate is set-only
            if (hwdata[`WDG_ACT_BIT]) begin
                act_next = 1'b1;
            end
        end
        if (bus_wr_reg && bus_ok_reg && reg_hit(bus_idx_reg, `WDG_CFG_IDX)) begin
            cfg_next = {4'h0, hwdata[3:1], 1'b0};
        end

        // R18: hardware option forces active
        active_next = act_next || hw_opt;

        // R14: no slow or wait input reaches this logic
        case (state_reg)
            WDG_RUN: begin
                if (halt_req) begin
                    if (rtc_en) begin
                        // R12: active-halt, no reset
                        state_next = WDG_AHALT;
                    end else if (halt_opt && active_next) begin
                        // R8: halt turns into reset
                        fire = 1'b1;
                    end else begin
                        // R9: one more decrement allowed
                        state_next = WDG_HALT_ONE;
                    end
                end
            end
            WDG_HALT_ONE: begin
                if (ext_wake) begin
                    state_next = WDG_WAKE;
                    wait_next = wake_cyc;
                end else if (tick) begin
                    // R9: stop after the single step
                    state_next = WDG_HALT_STOP;
                end
            end
            WDG_HALT_STOP: begin
                // R10: external wake waits before counting
                if (ext_wake) begin
                    state_next = WDG_WAKE;
                    wait_next = wake_cyc;
                end
            end
            WDG_AHALT: begin
                // R13: interrupt wake restarts at once
                if (osc_wake || ext_wake) begin
                    state_next = WDG_RUN;
                end
            end
            WDG_WAKE: begin
                if (wait_reg == 13'h0000) begin
                    state_next = WDG_RUN;
                    // R17: options latched once after startup
                    if (boot_reg) begin
                        boot_next = 1'b0;
                        opt_next = opt_sync_reg;
                    end
                end else begin
                    wait_next = wait_reg - 13'h0001;
                end
            end
            default: begin
                state_next = WDG_WAKE;
                wait_next = `WDG_WAKE_LONG;
            end
        endcase

        // R3: counter_msb falling while active
        // R7: write with msb clear forces reset
        if (!halted && active_next && !cnt_next[`WDG_MSB_BIT]
            && (cnt_reg[`WDG_MSB_BIT] || wr_ctrl)) begin
            fire = 1'b1;
        end

        // R3: reset pulse of fixed length
        if (fire && (rst_cnt_reg == 5'h00)) begin
            rst_cnt_next = 5'(`WDG_RST_CYC);
        end else if (rst_cnt_reg != 5'h00) begin
            rst_cnt_next = rst_cnt_reg - 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // R11: reset state deactivated, restart after delay
            // R13: counting resumes after the long delay
            state_reg <= WDG_WAKE;
            act_reg <= 1'b0;
            cnt_reg <= 7'h7F;
            pre_reg <= 14'h0000;
            wait_reg <= `WDG_WAKE_LONG;
            cfg_reg <= `WDG_CFG_RESET;
            boot_reg <= 1'b1;
            opt_reg <= 3'h0;
            rst_cnt_reg <= 5'h00;
            wdg_reset_n <= 1'b1;
            wdg_active <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            act_reg <= act_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            wait_reg <= wait_next;
            cfg_reg <= cfg_next;
            boot_reg <= boot_next;
            opt_reg <= opt_next;
            rst_cnt_reg <= rst_cnt_next;
            wdg_reset_n <= (rst_cnt_next == 5'h00);
            wdg_active <= act_next || opt_next[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus next state, reads except status see this cycle's writes
    always_comb begin
        bus_wr_next = 1'b0;
        bus_ok_next = 1'b0;
        bus_idx_next = bus_idx_reg;
        hrdata_next = 32'h0000_0000;
        stat_val = {rst_cnt_reg != 5'h00, opt_reg[2], opt_reg[1], opt_reg[0],
            state_reg == WDG_WAKE, state_reg == WDG_AHALT, halted, act_reg || hw_opt};
        if (addr_phase) begin
            bus_wr_next = hwrite;
            bus_ok_next = addr_ok;
            bus_idx_next = addr_idx;
            if (!hwrite && addr_ok) begin
                if (reg_hit(addr_idx, `WDG_CTRL_IDX)) begin
                    hrdata_next = {24'h00_0000, act_next, cnt_next};
                end else if (reg_hit(addr_idx, `WDG_CFG_IDX)) begin
                    hrdata_next = {24'h00_0000, cfg_next};
                end else if (reg_hit(addr_idx, `WDG_STAT_IDX)) begin
                    hrdata_next = {24'h00_0000, stat_val};
                end else if (reg_hit(addr_idx, `WDG_TBINFO_IDX)) begin
                    // R15: min/max timeout constants for software
                    // R16: per selected timebase
                    hrdata_next = {16'h0000, tb_info(cfg_next[`WDG_CFG_TB_LO +: 2])};
                end else begin
                    hrdata_next = 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus registers, zero wait state, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_wr_reg <= 1'b0;
            bus_ok_reg <= 1'b0;
            bus_idx_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            bus_wr_reg <= bus_wr_next;
            bus_ok_reg <= bus_ok_next;
            bus_idx_reg <= bus_idx_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // hsize unused: only whole words are carried
    logic unused_size;
    assign unused_size = ^hsize;

endmodule

// file: verification/wdg_top_chk.sv
`timescale 1ns/10ps
module wdg_top_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire wdg_pkg::wdg_word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire wdg_pkg::wdg_word_t hwdata,
    input wire logic hready,
    input wire wdg_pkg::wdg_word_t hrdata,
    input wire logic wdg_reset_n,
    input wire logic wdg_active
);
    import wdg_pkg::*;
    logic [4:0] low_cnt;
    logic wr_q;
    logic rd_q;
    logic ctrl_hit;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign ctrl_hit = hsel && hready && htrans[1] && haddr == 32'h0000_00A8;
    // low run length and data-phase flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= 5'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            low_cnt <= wdg_reset_n ? 5'h00 : low_cnt + 5'h01;
            wr_q <= ctrl_hit && hwrite;
            rd_q <= ctrl_hit && !hwrite;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_pulse_len;
        $rose(wdg_reset_n) |-> low_cnt == 5'h14;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse not 20 cycles");
    property p_pulse_max;
        !wdg_reset_n |-> low_cnt < 5'h14;
    endproperty
    a_pulse_max: assert property (p_pulse_max)
        else $error("reset pulse too long");
    property p_sw_reset;
        wr_q && hwdata[7:6] == 2'b10 && wdg_reset_n |=> !wdg_reset_n;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("forced reset missing");
    property p_sticky;
        wdg_active |=> wdg_active;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("activation lost");
    property p_act_set;
        wr_q && hwdata[7] |=> wdg_active;
    endproperty
    a_act_set: assert property (p_act_set)
        else $error("activate write ignored");
    property p_no_rst;
        !wdg_active && wdg_reset_n && !(wr_q && hwdata[7]) |=> wdg_reset_n;
    endproperty
    a_no_rst: assert property (p_no_rst)
        else $error("reset while inactive");
    property p_reset_vals;
        $rose(hresetn) |-> hrdata == 32'h0000_0000 && wdg_reset_n && !wdg_active;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("bad values after reset");
    property p_rd_act;
        rd_q && hrdata[7] |-> wdg_active && hrdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_act: assert property (p_rd_act)
        else $error("read activate bit without active");
endmodule
bind wdg_top wdg_top_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .wdg_reset_n(wdg_reset_n), .wdg_active(wdg_active));

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    import wdg_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, halt_req, ext_wake, osc_wake;
    logic ce, opt_hw, opt_halt, opt_long, hreadyout, hresp, wdg_reset_n, wdg_active;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wdg_word_t haddr, hwdata, hrdata, r;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int t0, cnt, n;
    logic [15:0] tb_info [4];
    wdg_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_tick(ce),
        .halt_req(halt_req), .ext_wake(ext_wake), .osc_wake(osc_wake),
        .pin_hw_wdg_opt(opt_hw), .pin_halt_reset_opt(opt_halt),
        .pin_long_wake_opt(opt_long), .wdg_reset_n(wdg_reset_n), .wdg_active(wdg_active));
    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        chk(r, exp);
    endtask
    // wait for the next count step, then compare with the model
    task automatic poll();
        logic [7:0] old;
        bus(32'h0000_00A8, 1'b0, 32'h0000_0000);
        old = r[7:0];
        n = 0;
        do begin
            bus(32'h0000_00A8, 1'b0, 32'h0000_0000);
            n++;
        end while (r[7:0] === old && n < 9000);
        cnt--;
        chk(r, 32'(cnt));
    endtask
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge hclk);
        fail_count++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, halt_req, ext_wake, osc_wake} = '0;
        {opt_hw, opt_halt, opt_long, hresetn} = '0;
        ce = 1'b1;
        hsize = 3'b010;
        tb_info = '{{8'd4, 8'd59}, {8'd8, 8'd53}, {8'd20, 8'd35}, {8'd49, 8'd54}};
        void'($urandom(32'he08fc237));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h0000_00A8, 32'h0000_007F);
        rd(32'h0000_00AC, 32'h0000_0000);
        rd(32'h0000_0400, 32'h0000_0000);
        repeat (4110) @(posedge hclk);
        cnt = {2'b01, 6'($urandom)};
        bus(32'h0000_00A8, 1'b1, 32'(cnt));
        poll();
        t0 = cyc;
        poll();
        chk(32'((cyc - t0 + 4) / 8), 32'(16384 / 8));
        bus(32'h0000_00A8, 1'b1, 32'h0000_00FF);
        #1;
        chk(wdg_active, 1'b1);
        bus(32'h0000_00A8, 1'b1, 32'h0000_007F);
        rd(32'h0000_00A8, 32'h0000_00FF);
        bus(32'h0000_00AC, 1'b1, 32'h0000_0002);
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        rd(32'h0000_00B0, 32'h0000_0007);
        osc_wake <= 1'b1;
        @(posedge hclk);
        osc_wake <= 1'b0;
        rd(32'h0000_00B0, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            bus(32'h0000_00AC, 1'b1, 32'(i * 4));
            rd(32'h0000_00B4, 32'(tb_info[i]));
        end
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        rd(32'h0000_00B0, 32'h0000_0003);
        ext_wake <= 1'b1;
        @(posedge hclk);
        ext_wake <= 1'b0;
        repeat (240) @(posedge hclk);
        bus(32'h0000_00B0, 1'b0, 32'h0000_0000);
        chk(r[3], 1'b1);
        repeat (30) @(posedge hclk);
        rd(32'h0000_00B0, 32'h0000_0001);
        bus(32'h0000_00A8, 1'b1, 32'h0000_00C0);
        n = 0;
        while (wdg_reset_n === 1'b1 && n < 16500) begin
            @(posedge hclk);
            n++;
        end
        chk(wdg_reset_n, 1'b0);
        rd(32'h0000_00A8, 32'h0000_00BF);
        repeat (30) @(posedge hclk);
        bus(32'h0000_00A8, 1'b1, 32'h0000_0080);
        #1;
        chk(wdg_reset_n, 1'b0);
        repeat (30) @(posedge hclk);
        hresetn <= 1'b0;
        opt_hw <= 1'b1;
        opt_halt <= 1'b1;
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4110) @(posedge hclk);
        chk(wdg_active, 1'b1);
        rd(32'h0000_00A8, 32'h0000_007F);
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        @(posedge hclk);
        #1;
        chk(wdg_reset_n, 1'b0);
        end_sim();
    end
endmodule
